// ### design/cmsr_pkg.sv
// Constants shared by the converter mode and status register bank
`default_nettype none
package cmsr_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_FLAGS       = 3;
    // Register offsets
    localparam logic [7:0]  ALERT_MASK_ADDR = 8'h05;
    localparam logic [7:0]  MODE_CTRL_ADDR  = 8'h06;
    localparam logic [7:0]  STATUS_ADDR     = 8'h07;
    // Reset values
    localparam logic [7:0]  ALERT_MASK_RST  = 8'hE0;
    localparam logic [7:0]  MODE_CTRL_RST   = 8'h20;
    localparam logic [7:0]  STATUS_RST      = 8'h03;
    // Writable bits; everything else is reserved and reads zero
    localparam logic [7:0]  MODE_CTRL_WMASK = 8'hFA;
    localparam logic [7:0]  ALERT_MASK_WMASK = 8'hE0;
    // Mode control fields
    localparam int          OUTPUT_ON_BIT   = 7;
    localparam int          FREQ_DBL_BIT    = 6;
    localparam int          SHORT_RETRY_BIT = 5;
    localparam int          SHDN_DRAIN_BIT  = 4;
    localparam int          FORCED_DRAIN_BIT = 3;
    localparam int          LIGHT_LOAD_FORCED_PWM_BIT        = 1;
    // Status and mask fields: flags occupy the top three bits
    localparam int          FLAG_LSB        = 5;
    localparam int          SHORT_IDX       = 2;
    localparam int          OVERCUR_IDX     = 1;
    localparam int          OVERVOLT_IDX    = 0;
    localparam int          PHASE_LSB       = 0;
    // Conversion phase codes
    localparam logic [1:0]  PHASE_BOOST     = 2'h0;
    localparam logic [1:0]  PHASE_BUCK      = 2'h1;
    localparam logic [1:0]  PHASE_BB        = 2'h2;
    localparam logic [1:0]  PHASE_RSVD      = 2'h3;
endpackage : cmsr_pkg
`default_nettype wire

// ### design/cmsr_core_if.sv
// Carrier between the register bank and its flag and drive submodules
`timescale 1ns/1ns
`default_nettype none
interface cmsr_core_if;
    logic [2:0] fault_cond;
    logic       flag_clr;
    logic [2:0] flags;
    logic [7:0] mode;
    logic [1:0] phase;
    modport top_mp (output fault_cond, output flag_clr, input flags,
                    output mode, output phase);
    modport flag_mp (input fault_cond, input flag_clr, output flags);
    modport drive_mp (input mode, input phase);
endinterface : cmsr_core_if
`default_nettype wire

// ### design/cmsr_flag_bank.sv
// Sticky protection flags, cleared by a status read
`timescale 1ns/1ns
`default_nettype none
module cmsr_flag_bank #(
    parameter int N = cmsr_pkg::NUM_FLAGS
) (
    // Clock and control
    input  wire logic      clk_in,
    input  wire logic      sys_rst_in,
    input  wire logic      ce_in,
    // Core carrier
    cmsr_core_if.flag_mp   core
);
    logic [N-1:0] flag_r;
    logic [N-1:0] flag_nxt;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            // A condition seen in the clearing cycle keeps the flag set
            assign flag_nxt[g] = core.fault_cond[g] |
                                 (flag_r[g] & ~core.flag_clr); // see RULE10 see RULE16
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_r <= '0;
        end else if (ce_in) begin
            flag_r <= flag_nxt;
        end
    end

    assign core.flags = flag_r;
endmodule : cmsr_flag_bank
`default_nettype wire

// ### design/cmsr_drive_ctrl.sv
// Registered control lines toward the power stage, derived from mode control
`timescale 1ns/1ns
`default_nettype none
module cmsr_drive_ctrl (
    // Clock and control
    input  wire logic      clk_in,
    input  wire logic      sys_rst_in,
    input  wire logic      ce_in,
    // Core carrier
    cmsr_core_if.drive_mp  core,
    // Power stage controls
    output logic           output_enable_out,
    output logic           freq_double_out,
    output logic           short_retry_en_out,
    output logic           drain_sink_on_out,
    output logic           light_load_light_load_forced_pwm_out
);
    wire out_on_w     = core.mode[cmsr_pkg::OUTPUT_ON_BIT];
    wire in_bb_w      = (core.phase == cmsr_pkg::PHASE_BB);
    wire dbl_nxt_w    = core.mode[cmsr_pkg::FREQ_DBL_BIT] & in_bb_w;  // see RULE2
    wire drain_nxt_w  = (core.mode[cmsr_pkg::SHDN_DRAIN_BIT] & ~out_on_w) // see RULE4
                      | core.mode[cmsr_pkg::FORCED_DRAIN_BIT];         // see RULE5

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            output_enable_out   <= 1'b0;
            freq_double_out     <= 1'b0;
            short_retry_en_out  <= 1'b1;
            drain_sink_on_out   <= 1'b0;
            light_load_light_load_forced_pwm_out <= 1'b0;
        end else if (ce_in) begin
            output_enable_out   <= out_on_w;                              // see RULE1
            freq_double_out     <= dbl_nxt_w;
            short_retry_en_out  <= core.mode[cmsr_pkg::SHORT_RETRY_BIT];  // see RULE3
            drain_sink_on_out   <= drain_nxt_w;
            light_load_light_load_forced_pwm_out <= core.mode[cmsr_pkg::LIGHT_LOAD_FORCED_PWM_BIT];         // see RULE7
        end
    end
endmodule : cmsr_drive_ctrl
`default_nettype wire

// ### design/cmsr_regs.sv
// Mode control, alert mask and fault/phase status registers of the converter
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1: Output stays off while mode bit 7 is 0 (reset); on when set.
// RULE2: Mode bit 6 set doubles switching frequency in buck-boost phase only.
// RULE3: Mode bit 5 resets to 1 and enables short-circuit retry while set.
// RULE4: Mode bit 4 with output off turns on the 100mA output drain sink.
// RULE5: Mode bit 3 forces the drain sink on regardless of shutdown.
// RULE6: Host keeps forced drain under 10ms when output exceeds 10V.
// RULE7: Mode bit 1 picks forced PWM (1) or pulse-frequency (0) at light load.
// RULE8: Alert pin goes low while any flag is set with its mask set.
// RULE9: Reading the status register clears the three protection flags.
// RULE10: Flags stay set until read; a persisting fault sets them again.
// RULE11: Status bit 7 is the short flag, reset 0.
// RULE12: Status bit 6 is the overcurrent flag, reset 0.
// RULE13: Status bit 5 is the overvoltage flag, reset 0.
// RULE14: Status bits 1-0 give phase: boost, buck, buck-boost; 11 after reset.
// RULE15: Alert masks sit in bits 7-5 of register 05h, reset 1, 1 enables.
// RULE16: Fault and phase inputs are synchronous; flag sets on any active cycle.
// RULE17: Reserved bits read 0 and ignore writes.
module cmsr_regs (
    // Clock, reset and enable
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // Register access port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    output logic             reg_rvalid_out,
    // Conditions from the analog section
    input  wire logic        short_det_in,
    input  wire logic        overcurrent_det_in,
    input  wire logic        overvoltage_det_in,
    input  wire logic [1:0]  phase_in,
    // Power stage controls
    output logic             output_enable_out,
    output logic             freq_double_out,
    output logic             short_retry_en_out,
    output logic             drain_sink_on_out,
    output logic             light_load_light_load_forced_pwm_out,
    // Alert pin
    output logic             fault_alert_n_out
);
    cmsr_core_if core ();

    // Stored registers
    logic [7:0] mode_control_r;
    logic [7:0] mode_control_nxt;
    logic [7:0] alert_mask_r;
    logic [7:0] alert_mask_nxt;
    logic [1:0] phase_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       alert_n_r;

    // Address decode
    wire sel_mask_w   = (reg_addr_in == cmsr_pkg::ALERT_MASK_ADDR);
    wire sel_mode_w   = (reg_addr_in == cmsr_pkg::MODE_CTRL_ADDR);
    wire sel_status_w = (reg_addr_in == cmsr_pkg::STATUS_ADDR);

    // A read takes priority if both strobes arrive together
    wire rd_go_w      = reg_rd_in;
    wire wr_go_w      = reg_wr_in & ~reg_rd_in;
    wire wr_mode_w    = wr_go_w & sel_mode_w;
    wire wr_mask_w    = wr_go_w & sel_mask_w;
    wire rd_status_w  = rd_go_w & sel_status_w;

    // Reserved bits are never stored, so they always read zero
    assign mode_control_nxt = wr_mode_w ? (reg_wdata_in & cmsr_pkg::MODE_CTRL_WMASK)
                                        : mode_control_r; // see RULE17
    assign alert_mask_nxt   = wr_mask_w ? (reg_wdata_in & cmsr_pkg::ALERT_MASK_WMASK)
                                        : alert_mask_r;   // see RULE15 see RULE17

    // Status word assembled from live flags and captured phase
    wire [2:0] flags_w = core.flags;
    wire [7:0] status_w = {flags_w, 3'h0, phase_r}; // see RULE11 see RULE12 see RULE13 see RULE14

    // Read data mux; unmapped addresses return zero
    assign rdata_nxt = sel_mode_w   ? mode_control_r :
                       sel_mask_w   ? alert_mask_r   :
                       sel_status_w ? status_w       : 8'h00;

    // Flag conditions, indexed to match the status bit order
    assign core.fault_cond[cmsr_pkg::SHORT_IDX]    = short_det_in;       // see RULE16
    assign core.fault_cond[cmsr_pkg::OVERCUR_IDX]  = overcurrent_det_in;
    assign core.fault_cond[cmsr_pkg::OVERVOLT_IDX] = overvoltage_det_in;
    // Clear only when the read is actually taken, so a frozen cycle loses nothing
    assign core.flag_clr = rd_status_w & ce_in; // see RULE9
    assign core.mode     = mode_control_r;
    assign core.phase    = phase_r;

    // Alert from flags gated by their masks
    wire [2:0] armed_w  = flags_w & alert_mask_r[cmsr_pkg::FLAG_LSB +: 3];
    wire       alert_nxt = ~(|armed_w); // see RULE8

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_control_r <= cmsr_pkg::MODE_CTRL_RST; // see RULE1 see RULE3
            alert_mask_r   <= cmsr_pkg::ALERT_MASK_RST;
        end else if (ce_in) begin
            mode_control_r <= mode_control_nxt;
            alert_mask_r   <= alert_mask_nxt;
        end
    end

    // Phase sampled every enabled cycle; reserved code until the first sample
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_r <= cmsr_pkg::STATUS_RST[1:0]; // see RULE14
        end else if (ce_in) begin
            phase_r <= phase_in;
        end
    end

    // Read data captured before the flags clear on the same edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (ce_in) begin
            rvalid_r <= rd_go_w;
            if (rd_go_w) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            alert_n_r <= 1'b1;
        end else if (ce_in) begin
            alert_n_r <= alert_nxt;
        end
    end

    assign reg_rdata_out     = rdata_r;
    assign reg_rvalid_out    = rvalid_r;
    assign fault_alert_n_out = alert_n_r;

    cmsr_flag_bank #(
        .N (cmsr_pkg::NUM_FLAGS)
    ) u_flags (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .core       (core.flag_mp)
    );

    // Drain, frequency and enable lines; forced drain time is the host's duty
    cmsr_drive_ctrl u_drive (
        .clk_in              (clk_in),
        .sys_rst_in          (sys_rst_in),
        .ce_in               (ce_in),
        .core                (core.drive_mp),
        .output_enable_out   (output_enable_out),
        .freq_double_out     (freq_double_out),
        .short_retry_en_out  (short_retry_en_out),
        .drain_sink_on_out   (drain_sink_on_out),
        .light_load_light_load_forced_pwm_out (light_load_light_load_forced_pwm_out)
    );
endmodule : cmsr_regs
`default_nettype wire

// ### verification/cmsr_properties.sv
// Port-level assertions for the mode and status register bank
`timescale 1ns/1ns
`default_nettype none
module cmsr_properties (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       short_det_in,
    input wire logic       overcurrent_det_in,
    input wire logic       overvoltage_det_in,
    input wire logic [1:0] phase_in,
    input wire logic       output_enable_out,
    input wire logic       freq_double_out,
    input wire logic       short_retry_en_out,
    input wire logic       drain_sink_on_out,
    input wire logic       light_load_light_load_forced_pwm_out,
    input wire logic       fault_alert_n_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic [2:0] det = {short_det_in, overcurrent_det_in, overvoltage_det_in};
    wire logic rd_take = ce_in && reg_rd_in;
    wire logic rd_stat = rd_take && reg_addr_in == 8'h07;
    wire logic wr_take = ce_in && reg_wr_in && !reg_rd_in;
    wire logic wr_mode = wr_take && reg_addr_in == 8'h06;
    // Mask copy lets the alert check skip faults the host has masked
    logic [2:0] mask_r;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) mask_r <= 3'h7;
        else if (wr_take && reg_addr_in == 8'h05) mask_r <= reg_wdata_in[7:5];
    end
    sequence s_mode_wr;
        wr_mode ##1 ce_in;
    endsequence
    sequence s_fault_then_read;
        ce_in && det != 3'h0 ##1 rd_stat;
    endsequence
    a_enable_follows: assert property (s_mode_wr |=> output_enable_out == $past(reg_wdata_in[7], 2)) else $error("output enable wrong");
    a_freq_double: assert property (s_mode_wr |=> freq_double_out == ($past(reg_wdata_in[6], 2) && $past(phase_in, 2) == 2'h2)) else $error("frequency doubling wrong");
    a_retry_follows: assert property (s_mode_wr |=> short_retry_en_out == $past(reg_wdata_in[5], 2)) else $error("retry enable wrong");
    a_drain_sink: assert property (s_mode_wr |=> drain_sink_on_out == (($past(reg_wdata_in[4], 2) && !$past(reg_wdata_in[7], 2)) || $past(reg_wdata_in[3], 2))) else $error("drain sink wrong");
    a_light_load_forced_pwm_follows: assert property (s_mode_wr |=> light_load_light_load_forced_pwm_out == $past(reg_wdata_in[1], 2)) else $error("light load mode wrong");
    a_alert_low: assert property (ce_in && (det & mask_r) != 3'h0 && !reg_wr_in ##1 ce_in |=> !fault_alert_n_out) else $error("alert not driven low");
    a_read_clears: assert property (rd_stat && det == 3'h0 ##1 det == 3'h0 ##1 rd_stat |=> reg_rdata_out[7:5] == 3'h0) else $error("flags not cleared by read");
    a_flag_sticky: assert property (s_fault_then_read |=> (reg_rdata_out[7:5] & $past(det, 2)) == $past(det, 2)) else $error("flag not reported");
    a_phase_report: assert property (ce_in ##1 rd_stat |=> reg_rdata_out[1:0] == $past(phase_in, 2)) else $error("phase code wrong");
    a_mode_reserved: assert property (rd_take && reg_addr_in == 8'h06 |=> (reg_rdata_out & 8'h05) == 8'h00) else $error("reserved mode bits set");
endmodule : cmsr_properties
bind cmsr_regs cmsr_properties chk (.clk_in, .sys_rst_in, .ce_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .short_det_in, .overcurrent_det_in,
    .overvoltage_det_in, .phase_in, .output_enable_out, .freq_double_out,
    .short_retry_en_out, .drain_sink_on_out, .light_load_light_load_forced_pwm_out, .fault_alert_n_out);
`default_nettype wire

// ### verification/cmsr_host_model.sv
// Host side of the register strobe port
`timescale 1ns/1ns
`default_nettype none
module cmsr_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output var  logic [7:0] addr_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [7:0] wdata_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // Forced drain is only left on for a few cycles
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        // Released data shows a changed value, never the stale one
        wdata_out <= ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rvalid_in === 1'b1) begin
                ok = 1'b1;
                d = rdata_in;
            end else @(posedge clk_in);
        end
    endtask : rd_reg
endmodule : cmsr_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Directed testbench for the mode and status register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       ce_in = 1'b1;
    logic [2:0] det = 3'h0;
    logic [1:0] phase = 2'h3;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, rvalid, oe, fd, rt, dr, fp, alert_n;
    int         n_mismatch = 0;
    int         n_tests = 0;
    logic [7:0] mode_tab [6] = '{8'h80, 8'h10, 8'h98, 8'h42, 8'h00, 8'hFF};
    cmsr_regs dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .short_det_in(det[2]), .overcurrent_det_in(det[1]),
        .overvoltage_det_in(det[0]), .phase_in(phase), .output_enable_out(oe),
        .freq_double_out(fd), .short_retry_en_out(rt), .drain_sink_on_out(dr),
        .light_load_light_load_forced_pwm_out(fp), .fault_alert_n_out(alert_n));
    cmsr_host_model host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd_reg(a, d, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t no read answer", $time);
            results();
        end else chk(d, exp);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("[FAIL] %0t run did not finish", $time);
        results();
    end
    initial begin
        logic [7:0] m;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        tick(1);
        chk({oe, fd, rt, dr, fp, alert_n, 2'h0}, 8'h24);
        rd_chk(8'h07, 8'h03);
        rd_chk(8'h06, 8'h20);
        rd_chk(8'h05, 8'hE0);
        @(posedge clk_in);
        phase <= 2'h2;
        for (int i = 0; i < 6; i++) begin
            m = mode_tab[i];
            host.wr_reg(8'h06, m);
            tick(2);
            chk({oe, fd, rt, dr, fp, 3'h0}, {m[7:5], (m[4] & ~m[7]) | m[3], m[1], 3'h0});
            rd_chk(8'h06, m & 8'hFA);
        end
        @(posedge clk_in);
        phase <= 2'h1;
        tick(3);
        chk({7'h0, fd}, 8'h00);
        host.wr_reg(8'h06, 8'h20);
        @(posedge clk_in);
        det <= 3'h4;
        @(posedge clk_in);
        det <= 3'h0;
        tick(2);
        chk({7'h0, alert_n}, 8'h00);
        rd_chk(8'h07, 8'h81);
        rd_chk(8'h07, 8'h01);
        tick(2);
        chk({7'h0, alert_n}, 8'h01);
        @(posedge clk_in);
        det <= 3'h1;
        rd_chk(8'h07, 8'h21);
        rd_chk(8'h07, 8'h21);
        @(posedge clk_in);
        det <= 3'h0;
        rd_chk(8'h07, 8'h21);
        rd_chk(8'h07, 8'h01);
        // Overcurrent masked: flag sets but the pin stays high
        host.wr_reg(8'h05, 8'hBF);
        rd_chk(8'h05, 8'hA0);
        @(posedge clk_in);
        det <= 3'h2;
        @(posedge clk_in);
        det <= 3'h0;
        tick(3);
        chk({7'h0, alert_n}, 8'h01);
        rd_chk(8'h07, 8'h41);
        host.wr_reg(8'h07, 8'hFF);
        rd_chk(8'h07, 8'h01);
        rd_chk(8'h3C, 8'h00);
        @(posedge clk_in);
        ce_in <= 1'b0;
        host.wr_reg(8'h06, 8'h80);
        @(posedge clk_in);
        ce_in <= 1'b1;
        rd_chk(8'h06, 8'h20);
        // Boost code is the only phase not reached above
        @(posedge clk_in);
        phase <= 2'h0;
        rd_chk(8'h07, 8'h00);
        results();
    end
endmodule : tb_top
`default_nettype wire
